// ===== sim/scir_bus_model.sv
// Purpose: Far-side bus device driving phase, data and reset lines
// Assumes: Terminated lines idle low in active-high terms
// Notes: Control pack is rst,bsy,req,msg,cd,io,sel
`timescale 1ns/1ps
`default_nettype none
module scir_bus_model (
   input wire logic clk_i,
   output logic [6:0] ctl_o,
   output logic [7:0] db_o,
   output logic dbp_o
);
   // ==========================================
   // Line state
   initial begin
      ctl_o = 7'h00;
      db_o = 8'h00;
      dbp_o = 1'b1;
   end
   // Good parity is odd over nine bits; bad is only sent on purpose
   task automatic drive(input logic [6:0] c, input logic [7:0] d, input logic good);
      @(posedge clk_i);
      ctl_o <= c;
      db_o <= d;
      dbp_o <= good ? ~^d : ^d;
   endtask
endmodule
`default_nettype wire

// ===== sim/scir_core_props.sv
// Purpose: Port checker for the interrupt and reset block
// Assumes: Single clock, async active-low reset
// Notes: Latency bounds include the two-flop input sync
`timescale 1ns/1ps
`default_nettype none
module scir_core_props (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic rst_i,
   input wire logic dma_xfer_i,
   input wire logic dma_zero_i,
   input wire logic rst_o,
   input wire logic rst_oe_o,
   input wire logic bus_oe_o,
   input wire logic dma_stop_o,
   input wire logic irq_o
);
   // ==========================================
   // Helpers
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   logic clr_take;
   logic clr_ff;
   logic [2:0] clr_age_ff;
   logic [2:0] zero_age_ff;
   assign clr_take = s_axi_arvalid && s_axi_arready && (s_axi_araddr == scir_pkg::OFS_CLEAR);
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         clr_ff <= 1'b0;
         clr_age_ff <= 3'h7;
         zero_age_ff <= 3'h7;
      end else begin
         if (s_axi_arvalid && s_axi_arready) clr_ff <= clr_take;
         clr_age_ff <= clr_take ? 3'h0 : (clr_age_ff == 3'h7 ? 3'h7 : clr_age_ff + 3'h1);
         zero_age_ff <= (dma_xfer_i && dma_zero_i) ? 3'h0 : (zero_age_ff == 3'h7 ? 3'h7 : zero_age_ff + 3'h1);
      end
   end
   // ==========================================
   // Assertions
   rst_irq_a: assert property ($rose(rst_i) |-> ##[1:8] irq_o)
      else $error("irq missing after bus reset");
   rst_release_a: assert property ($rose(rst_i) |-> ##[1:16] !bus_oe_o)
      else $error("bus not released after reset");
   hw_reset_a: assert property ($rose(resetn_i) |-> !rst_oe_o && !bus_oe_o && !irq_o)
      else $error("outputs active after hardware reset");
   own_rst_a: assert property (rst_o |-> rst_oe_o && !bus_oe_o)
      else $error("reset line driven without enable or with bus held");
   pend_hold_a: assert property ($fell(irq_o) |-> clr_age_ff < 3'h5)
      else $error("pending dropped without clear read");
   clr_data_a: assert property (s_axi_rvalid && clr_ff |-> s_axi_rdata == 32'h0)
      else $error("clear read returned data");
   stop_cause_a: assert property ($rose(dma_stop_o) |-> zero_age_ff < 3'h4)
      else $error("dma stop without count end");
   rst_pend_a: assert property (rst_i [*8] |-> irq_o)
      else $error("pending not set during reset");
   c_irq: cover property ($rose(irq_o));
   c_stop: cover property ($rose(dma_stop_o));
   c_rst: cover property ($rose(rst_o));
endmodule
bind scir_core scir_core_props i_props (.mclk_i, .resetn_i, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .rst_i, .dma_xfer_i, .dma_zero_i, .rst_o, .rst_oe_o, .bus_oe_o, .dma_stop_o, .irq_o);
`default_nettype wire

// ===== sim/scir_core_test.sv
// Purpose: Register-level tests of interrupt sources and resets
// Assumes: 20 MHz clock, AXI4-Lite host
// Notes: Fixed waits cover sync plus 400 ns settle
`timescale 1ns/1ps
`default_nettype none
module scir_core_test;
   // ==========================================
   // Signals
   logic mclk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic dma_x = 1'b0, dma_z = 1'b0;
   logic int_mask = 1'b0, cpu_irq;
   logic awready, wready, bvalid, arready, rvalid, rst_o, rst_oe_o, bus_oe_o, dma_stop_o, irq_o, rst_w;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [6:0] ctl;
   logic [7:0] db;
   logic dbp;
   logic [7:0] modes [4] = '{8'h0a, 8'h02, 8'h30, 8'h20};
   int n_errors = 0;
   int total_checks = 0;
   always #25 mclk_i = ~mclk_i;
   // Wired reset: far side or own driver
   assign rst_w = ctl[6] | (rst_oe_o & rst_o);
   // System mask gate between the request line and the processor
   assign cpu_irq = irq_o & int_mask;
   scir_bus_model i_bus (.clk_i(mclk_i), .ctl_o(ctl), .db_o(db), .dbp_o(dbp));
   scir_core i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bsy_i(ctl[5]), .sel_i(ctl[0]),
      .rst_i(rst_w), .req_i(ctl[4]), .ack_i(1'b0), .msg_i(ctl[3]), .cd_i(ctl[2]), .io_i(ctl[1]),
      .db_i(db), .dbp_i(dbp), .dma_xfer_i(dma_x), .dma_zero_i(dma_z), .rst_o(rst_o),
      .rst_oe_o(rst_oe_o), .bus_oe_o(bus_oe_o), .dma_stop_o(dma_stop_o), .irq_o(irq_o));
   // ==========================================
   // Tasks
   task automatic stop_test;
      if (n_errors == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", (a > scir_pkg::OFS_SELENA) ? scir_pkg::RESP_ERR : scir_pkg::RESP_OK, bresp);
   endtask
   task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge mclk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("rresp", (a > 8'h1c) ? scir_pkg::RESP_ERR : scir_pkg::RESP_OK, rresp);
      chk($sformatf("reg_%h", a), e, rdata & m);
   endtask
   task automatic clr;
      rdm(scir_pkg::OFS_CLEAR, 32'hffffffff, 32'h0);
      wr(scir_pkg::OFS_MODE, 8'h00);
   endtask
   // ==========================================
   // Tests
   initial begin
      wt(8);
      resetn_i <= 1'b1;
      rdm(scir_pkg::OFS_MODE, 32'hff, 32'h0);
      chk("outs", 4'h0, {rst_o, rst_oe_o, bus_oe_o, irq_o});
      wr(8'h20, 8'h5a);
      rdm(8'h20, 32'hffffffff, 32'h0);
      i_bus.drive(7'h01, 8'h03, 1'b1);
      wt(30);
      chk("irq", 1'b0, irq_o);
      i_bus.drive(7'h00, 8'h00, 1'b1);
      wr(scir_pkg::OFS_SELENA, 8'h01);
      i_bus.drive(7'h01, 8'h03, 1'b1);
      wt(30);
      chk("irq", 1'b1, irq_o);
      chk("cpu_irq", 1'b0, cpu_irq);
      int_mask <= 1'b1;
      wt(1);
      chk("cpu_irq", 1'b1, cpu_irq);
      rdm(scir_pkg::OFS_STATUS, 32'h10, 32'h10);
      rdm(scir_pkg::OFS_CURSTAT, 32'h46, 32'h02);
      i_bus.drive(7'h00, 8'h00, 1'b1);
      wt(6);
      chk("irq", 1'b1, irq_o);
      clr();
      wt(4);
      chk("irq", 1'b0, irq_o);
      for (int k = 0; k < 4; k++) begin
         wr(scir_pkg::OFS_MODE, modes[k]);
         if (k < 2) begin
            @(posedge mclk_i);
            dma_x <= 1'b1;
            dma_z <= 1'b1;
            @(posedge mclk_i);
            dma_x <= 1'b0;
            dma_z <= 1'b0;
         end else begin
            i_bus.drive(7'h00, 8'h5a, 1'b0);
            wt(4);
            rdm(scir_pkg::OFS_CURDATA, 32'hff, 32'h5a);
            i_bus.drive(7'h00, 8'h00, 1'b1);
         end
         wt(10);
         chk("irq", modes[k][3] | modes[k][4], irq_o);
         chk("stop", k < 2, dma_stop_o);
         rdm(scir_pkg::OFS_STATUS, 32'ha0, (k < 2) ? 32'h80 : 32'h20);
         clr();
      end
      wr(scir_pkg::OFS_TARCMD, 8'h05);
      i_bus.drive(7'h0a, 8'h00, 1'b1);
      wt(8);
      rdm(scir_pkg::OFS_STATUS, 32'h09, 32'h08);
      wr(scir_pkg::OFS_MODE, 8'h02);
      i_bus.drive(7'h18, 8'h00, 1'b1);
      wt(10);
      chk("irq", 1'b1, irq_o);
      rdm(scir_pkg::OFS_STATUS, 32'h88, 32'h0);
      clr();
      i_bus.drive(7'h20, 8'h00, 1'b1);
      wt(4);
      wr(scir_pkg::OFS_MODE, 8'h04);
      i_bus.drive(7'h00, 8'h00, 1'b1);
      wt(3);
      i_bus.drive(7'h20, 8'h00, 1'b1);
      wt(20);
      chk("irq", 1'b0, irq_o);
      i_bus.drive(7'h00, 8'h00, 1'b1);
      wt(20);
      chk("irq", 1'b1, irq_o);
      rdm(scir_pkg::OFS_STATUS, 32'h04, 32'h04);
      clr();
      wr(scir_pkg::OFS_INICMD, 8'h01);
      wt(2);
      chk("bus_oe", 1'b1, bus_oe_o);
      wr(scir_pkg::OFS_MODE, 8'h02);
      i_bus.drive(7'h40, 8'h00, 1'b1);
      wt(16);
      chk("bus_oe", 1'b0, bus_oe_o);
      chk("irq", 1'b1, irq_o);
      rdm(scir_pkg::OFS_CURSTAT, 32'h80, 32'h80);
      rdm(scir_pkg::OFS_MODE, 32'hff, 32'h0);
      i_bus.drive(7'h00, 8'h00, 1'b1);
      wt(4);
      rdm(scir_pkg::OFS_CURSTAT, 32'h80, 32'h0);
      rdm(scir_pkg::OFS_STATUS, 32'h10, 32'h10);
      clr();
      wr(scir_pkg::OFS_INICMD, 8'h80);
      wt(8);
      chk("rst_o", 1'b1, rst_o);
      chk("irq", 1'b1, irq_o);
      rdm(scir_pkg::OFS_INICMD, 32'h80, 32'h80);
      wr(scir_pkg::OFS_INICMD, 8'h00);
      wt(2);
      chk("rst_o", 1'b0, rst_o);
      stop_test();
   end
   // Whole run is near 400 cycles; the limit at 8000 cycles ends a hang
   initial begin
      wt(8000);
      n_errors++;
      stop_test();
   end
endmodule
`default_nettype wire

// ===== verilog/scir_core.sv
// Purpose: Interrupt and reset logic of the parallel bus controller
// Assumes: AXI4-Lite slave, bus pins synchronised here
// Notes: Bus lines are active high inside; drive enables for release
// Operation
// - One interrupt output; its level shows in the status register
// - Selection interrupt: SEL, BSY false 400 ns, data AND enable nonzero
// - All-zero select enable blocks selection interrupts
// - Count reaching zero in DMA sets done, interrupts if enabled
// - No further DMA transfers once done is set
// - Parity error on DMA receive or data read sets flag
// - Phase signals compared continuously with target command bits
// - Mismatch with DMA and REQ raises interrupt
// - Busy monitor: BSY false 400 ns sets busy loss and interrupts
// - RST always interrupts and cannot be masked
// - Bus signals released within 800 ns of bus reset
// - RST status follows the live line unlatched
// - Hardware reset clears all and drives nothing, no RST
// - Received RST clears all but sets pending, keeps RST bit
// - Host RST clears all, sets pending, bit held until cleared
// - Clear-flags read clears parity, pending and busy loss; pending stays set while RST is active
`timescale 1ns/1ps
`default_nettype none
module scir_core (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic bsy_i,
   input wire logic sel_i,
   input wire logic rst_i,
   input wire logic req_i,
   input wire logic ack_i,
   input wire logic msg_i,
   input wire logic cd_i,
   input wire logic io_i,
   input wire logic [7:0] db_i,
   input wire logic dbp_i,
   input wire logic dma_xfer_i,
   input wire logic dma_zero_i,
   output logic rst_o,
   output logic rst_oe_o,
   output logic bus_oe_o,
   output logic dma_stop_o,
   output logic irq_o
);
   // ==========================================
   // Synchronisers
   localparam int NS = 16;
   logic [NS-1:0] raw;
   logic [NS-1:0] s1_ff;
   logic [NS-1:0] s2_ff;
   // Bus lines are asynchronous to mclk_i; two flops before any use
   assign raw = {db_i, dbp_i, bsy_i, sel_i, rst_i, req_i, msg_i, cd_i, io_i};
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s1_ff <= '0;
         s2_ff <= '0;
      end else begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
      end
   end
   logic [7:0] db_s;
   logic dbp_s, bsy_s, sel_s, rst_s, req_s, msg_s, cd_s, io_s;
   assign {db_s, dbp_s, bsy_s, sel_s, rst_s, req_s, msg_s, cd_s, io_s} = s2_ff;
   logic ack_s1_ff, ack_s_ff;
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack_s1_ff <= 1'b0;
         ack_s_ff <= 1'b0;
      end else begin
         ack_s1_ff <= ack_i;
         ack_s_ff <= ack_s1_ff;
      end
   end

   // Good parity: odd count over data and parity bit
   function automatic logic odd_ok(input logic [7:0] d, input logic p);
      odd_ok = ^{d, p};
   endfunction
   // Word aligned and not past the last register of the range
   function automatic logic addr_ok(input logic [7:0] a, input logic [7:0] last);
      addr_ok = (a[7:2] <= last[7:2]) && (a[1:0] == 2'b00);
   endfunction

   // ==========================================
   // Registers
   logic [7:0] mode_ff, tarcmd_ff, inicmd_ff, selena_ff;
   logic int_ff, parity_error_flag_ff, busy_loss_error_flag_ff, dma_done_flag_ff;
   logic bus_rst;
   logic soft_clr;
   logic clr_rd;
   logic curdata_rd;
   logic wr_go, rd_go;
   logic [7:0] waddr_ff;
   logic aw_got_ff, w_got_ff;
   logic [31:0] wdata_ff;

   // Live RST on the line, own or another device's
   assign bus_rst = rst_s | inicmd_ff[scir_pkg::INI_RST];
   assign soft_clr = bus_rst;

   // ==========================================
   // Timers for selection settle and busy loss
   scir_ev_if sel_ev ();
   scir_ev_if bsy_ev ();
   assign sel_ev.start = !bsy_s;
   assign bsy_ev.start = !bsy_s & mode_ff[scir_pkg::MODE_BUSY_MONITOR_ENABLE];
   scir_timer #(.COUNT(scir_pkg::SETTLE_CYC)) u_sel_tmr (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .ev(sel_ev.timer)
   );
   scir_timer #(.COUNT(scir_pkg::SETTLE_CYC)) u_bsy_tmr (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .ev(bsy_ev.timer)
   );

   // ==========================================
   // Event detection
   logic match;
   logic sel_hit, pm_hit, par_hit, end_hit, bl_hit;
   logic sel_hit_q_ff, pm_q_ff, bl_q_ff, rst_q_ff;
   assign match = ({msg_s, cd_s, io_s} == tarcmd_ff[2:0]);
   assign sel_hit = sel_s & sel_ev.done & (|(db_s & selena_ff));
   assign pm_hit = !match & mode_ff[scir_pkg::MODE_DMA] & req_s;
   assign bl_hit = bsy_ev.done;
   assign end_hit = mode_ff[scir_pkg::MODE_DMA] & dma_xfer_i & dma_zero_i;
   assign par_hit = mode_ff[scir_pkg::MODE_PARITY_CHECK_ENABLE] & !odd_ok(db_s, dbp_s)
                    & ((dma_xfer_i & mode_ff[scir_pkg::MODE_DMA]) | curdata_rd);

   // Last levels, so a held condition interrupts once
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sel_hit_q_ff <= 1'b0;
         pm_q_ff <= 1'b0;
         bl_q_ff <= 1'b0;
         rst_q_ff <= 1'b0;
      end else begin
         sel_hit_q_ff <= sel_hit;
         pm_q_ff <= pm_hit;
         bl_q_ff <= bl_hit;
         rst_q_ff <= bus_rst;
      end
   end

   // ==========================================
   // Sticky flags; set wins over a clear read
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         int_ff <= 1'b0;
      end else if ((sel_hit & !sel_hit_q_ff) | (pm_hit & !pm_q_ff) | (bl_hit & !bl_q_ff)
                   | (end_hit & mode_ff[scir_pkg::MODE_END_OF_TRANSFER_INT_ENABLE])
                   | (par_hit & mode_ff[scir_pkg::MODE_PARITY_INT_ENABLE])
                   | (bus_rst & !rst_q_ff)) begin
         int_ff <= 1'b1;
      end else if (clr_rd | soft_clr) begin
         int_ff <= int_ff & soft_clr;
      end
   end
   // Bus reset clears every flag; a clear read leaves the done flag alone
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         parity_error_flag_ff <= 1'b0;
         busy_loss_error_flag_ff <= 1'b0;
         dma_done_flag_ff <= 1'b0;
      end else begin
         if (par_hit & !soft_clr) parity_error_flag_ff <= 1'b1;
         else if (clr_rd | soft_clr) parity_error_flag_ff <= 1'b0;
         if (bl_hit & !soft_clr) busy_loss_error_flag_ff <= 1'b1;
         else if (clr_rd | soft_clr) busy_loss_error_flag_ff <= 1'b0;
         if (end_hit & !soft_clr) dma_done_flag_ff <= 1'b1;
         else if (soft_clr | !mode_ff[scir_pkg::MODE_DMA]) dma_done_flag_ff <= 1'b0;
      end
   end

   // ==========================================
   // Bus release and outputs
   // Enable drops on the first synchronised RST cycle, far inside the limit
   logic rel_ff;
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_o <= 1'b0;
         rst_oe_o <= 1'b0;
         bus_oe_o <= 1'b0;
         rel_ff <= 1'b0;
         dma_stop_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         rst_o <= inicmd_ff[scir_pkg::INI_RST];
         rst_oe_o <= inicmd_ff[scir_pkg::INI_RST];
         rel_ff <= bus_rst;
         bus_oe_o <= inicmd_ff[scir_pkg::INI_BUS] & !bus_rst & !rel_ff;
         dma_stop_o <= dma_done_flag_ff | end_hit;
         irq_o <= int_ff;
      end
   end

   // ==========================================
   // AXI4-Lite write
   // One write in flight; the readies return when the response is taken
   assign wr_go = aw_got_ff & w_got_ff & !s_axi_bvalid;
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         waddr_ff <= '0;
         wdata_ff <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= scir_pkg::RESP_OK;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_got_ff <= 1'b1;
            waddr_ff <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            s_axi_bresp <= addr_ok(waddr_ff, scir_pkg::OFS_SELENA) ? scir_pkg::RESP_OK : scir_pkg::RESP_ERR;
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end
   // Only byte lane 0 carries register data
   logic wstb;
   assign wstb = wr_go & s_axi_wstrb[0];
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_ff <= '0;
         tarcmd_ff <= '0;
         selena_ff <= '0;
      end else if (soft_clr) begin
         mode_ff <= '0;
         tarcmd_ff <= '0;
         selena_ff <= '0;
      end else if (wstb) begin
         if (waddr_ff == scir_pkg::OFS_MODE) mode_ff <= wdata_ff[7:0];
         if (waddr_ff == scir_pkg::OFS_TARCMD) tarcmd_ff <= wdata_ff[7:0];
         if (waddr_ff == scir_pkg::OFS_SELENA) selena_ff <= wdata_ff[7:0];
      end
   end
   // RST bit survives a bus reset; only host or hardware reset clears it
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         inicmd_ff <= '0;
      end else if (wstb & (waddr_ff == scir_pkg::OFS_INICMD)) begin
         inicmd_ff <= wdata_ff[7:0];
      end else if (soft_clr) begin
         inicmd_ff <= inicmd_ff & (8'h01 << scir_pkg::INI_RST);
      end
   end

   // ==========================================
   // AXI4-Lite read
   // Clear read acts at the address handshake and returns zero
   assign rd_go = s_axi_arvalid & s_axi_arready;
   assign clr_rd = rd_go & (s_axi_araddr == scir_pkg::OFS_CLEAR);
   assign curdata_rd = rd_go & (s_axi_araddr == scir_pkg::OFS_CURDATA);
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      case (s_axi_araddr)
         scir_pkg::OFS_MODE: rd_mux = mode_ff;
         scir_pkg::OFS_TARCMD: rd_mux = tarcmd_ff;
         scir_pkg::OFS_INICMD: rd_mux = inicmd_ff;
         scir_pkg::OFS_SELENA: rd_mux = selena_ff;
         scir_pkg::OFS_STATUS: begin
            rd_mux[scir_pkg::ST_DMA_DONE_FLAG] = dma_done_flag_ff;
            rd_mux[scir_pkg::ST_PARITY_ERROR_FLAG] = parity_error_flag_ff;
            rd_mux[scir_pkg::ST_INT] = int_ff;
            rd_mux[scir_pkg::ST_MATCH] = match;
            rd_mux[scir_pkg::ST_BUSY_LOSS_ERROR_FLAG] = busy_loss_error_flag_ff;
            rd_mux[scir_pkg::ST_ACK] = ack_s_ff;
         end
         scir_pkg::OFS_CURSTAT: begin
            rd_mux[scir_pkg::CS_RST] = rst_s;
            rd_mux[scir_pkg::CS_BSY] = bsy_s;
            rd_mux[scir_pkg::CS_REQ] = req_s;
            rd_mux[scir_pkg::CS_MSG] = msg_s;
            rd_mux[scir_pkg::CS_CD] = cd_s;
            rd_mux[scir_pkg::CS_IO] = io_s;
            rd_mux[scir_pkg::CS_SEL] = sel_s;
         end
         scir_pkg::OFS_CURDATA: rd_mux = db_s;
         default: rd_mux = 8'h00;
      endcase
   end
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= scir_pkg::RESP_OK;
      end else if (rd_go) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rd_mux};
         s_axi_rresp <= addr_ok(s_axi_araddr, scir_pkg::OFS_CLEAR) ? scir_pkg::RESP_OK : scir_pkg::RESP_ERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/scir_ev_if.sv
// Purpose: Event carrier between the timer and the main block
// Assumes: One clock domain
// Notes: Plain level signals
`timescale 1ns/1ps
`default_nettype none
interface scir_ev_if;
   logic start;
   logic done;
   modport timer (input start, output done);
   modport user (output start, input done);
endinterface
`default_nettype wire

// ===== verilog/scir_pkg.sv
// Purpose: Shared constants for the bus controller interrupt and reset block
// Assumes: AXI4-Lite register access, 20 MHz clock
// Notes: Register offsets are byte addresses
`default_nettype none
package scir_pkg;
   // ==========================================
   // Timing
   localparam int CLK_HZ = 20000000;
   localparam int SETTLE_NS = 400;
   localparam int RELEASE_NS = 800;
   localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int RELEASE_CYC = (RELEASE_NS * (CLK_HZ / 1000000)) / 1000;
   localparam int CNT_W = 5;
   // ==========================================
   // Register offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_TARCMD = 8'h04;
   localparam logic [7:0] OFS_INICMD = 8'h08;
   localparam logic [7:0] OFS_SELENA = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_CURSTAT = 8'h14;
   localparam logic [7:0] OFS_CURDATA = 8'h18;
   localparam logic [7:0] OFS_CLEAR = 8'h1c;
   // ==========================================
   // Config bits
   localparam int MODE_DMA = 1;
   localparam int MODE_BUSY_MONITOR_ENABLE = 2;
   localparam int MODE_END_OF_TRANSFER_INT_ENABLE = 3;
   localparam int MODE_PARITY_INT_ENABLE = 4;
   localparam int MODE_PARITY_CHECK_ENABLE = 5;
   localparam int INI_RST = 7;
   localparam int INI_BUS = 0;
   // Status bits
   localparam int ST_ACK = 0;
   localparam int ST_BUSY_LOSS_ERROR_FLAG = 2;
   localparam int ST_MATCH = 3;
   localparam int ST_INT = 4;
   localparam int ST_PARITY_ERROR_FLAG = 5;
   localparam int ST_DMA_DONE_FLAG = 7;
   // Current bus status bits
   localparam int CS_IO = 2;
   localparam int CS_SEL = 1;
   localparam int CS_BSY = 6;
   localparam int CS_RST = 7;
   localparam int CS_REQ = 5;
   localparam int CS_MSG = 4;
   localparam int CS_CD = 3;
   localparam logic [1:0] RESP_OK = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;
endpackage
`default_nettype wire

// ===== verilog/scir_timer.sv
// Purpose: Counts how long a level has held
// Assumes: Synchronous level in
// Notes: Done stays high while level holds past the count
`timescale 1ns/1ps
`default_nettype none
module scir_timer #(
   parameter int COUNT = 8
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   scir_ev_if.timer ev
);
   logic [scir_pkg::CNT_W-1:0] cnt_ff;
   logic done_ff;
   assign ev.done = done_ff;
   // ==========================================
   // Counter
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_ff <= '0;
         done_ff <= 1'b0;
      end else if (!ev.start) begin
         cnt_ff <= '0;
         done_ff <= 1'b0;
      end else if (cnt_ff >= scir_pkg::CNT_W'(COUNT - 1)) begin
         done_ff <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end
endmodule
`default_nettype wire
